// [core/bsfx_pkg.sv]
// constants, types and register map of the bit, shift and flag unit
// assumes a 32-bit APB master and one 50 MHz core clock
package bsfx_pkg;

    // ********************
    // register map
    // ********************
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [2:0] WREG_PAGE = 3'h1;
    localparam logic [2:0] IO_PAGE = 3'h2;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 3;
    localparam int NUM_REGS = 8;
    localparam int STAT_BUSY = 0;

    // ********************
    // command word fields
    // ********************
    localparam int OP_W = 5;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SEL_LSB = 8;
    localparam int CMD_BIT_LSB = 12;

    // ********************
    // status flag positions and reset values
    // ********************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] REG_RST = 8'h00;

    // ********************
    // operation codes
    // ********************
    localparam logic [4:0] OP_CLEAR_IO_BIT = 5'h00;
    localparam logic [4:0] OP_SHIFT_LEFT_LOGICAL = 5'h01;
    localparam logic [4:0] OP_SHIFT_RIGHT_LOGICAL = 5'h02;
    localparam logic [4:0] OP_ROTATE_LEFT_THROUGH_CARRY = 5'h03;
    localparam logic [4:0] OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h04;
    localparam logic [4:0] OP_SHIFT_RIGHT_ARITHMETIC = 5'h05;
    localparam logic [4:0] OP_SWAP_NIBBLES = 5'h06;
    localparam logic [4:0] OP_SET_STATUS_FLAG = 5'h07;
    localparam logic [4:0] OP_CLEAR_STATUS_FLAG = 5'h08;
    localparam logic [4:0] OP_STORE_BIT_TO_TRANSFER_FLAG = 5'h09;
    localparam logic [4:0] OP_LOAD_BIT_FROM_TRANSFER_FLAG = 5'h0a;
    // 5'h10+f sets flag f, 5'h18+f clears it
    localparam int OP_DED_BIT = 4;
    localparam int OP_DED_CLR_BIT = 3;

    typedef struct packed {
        logic [4:0] op;
        logic [2:0] sel;
        logic [2:0] bitIdx;
    } bsfx_cmd_s;

    typedef enum logic [1:0] {ST_IDLE, ST_CLRIO} bsfx_state_e;
    typedef enum logic [2:0] {
        RG_NONE, RG_CMD, RG_FLAGS, RG_STAT, RG_WREG, RG_IO
    } bsfx_region_e;

endpackage

// [core/bsfx_exec_unit.sv]
// bit, shift and flag execution unit with its status and register files
// assumes an APB master on mclk; one access is served at a time
`timescale 1ns/1ns
module bsfx_exec_unit
    import bsfx_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    function automatic bsfx_region_e regionOf(input logic [7:0] a);
        if (a[IDX_LSB-1:0] != '0) begin
            return RG_NONE;
        end
        if (a == OFF_CMD) begin
            return RG_CMD;
        end
        if (a == OFF_FLAGS) begin
            return RG_FLAGS;
        end
        if (a == OFF_STAT) begin
            return RG_STAT;
        end
        if (a[7:IDX_LSB+IDX_W] == WREG_PAGE) begin
            return RG_WREG;
        end
        if (a[7:IDX_LSB+IDX_W] == IO_PAGE) begin
            return RG_IO;
        end
        return RG_NONE;
    endfunction

    // ********************
    // state
    // ********************
    bsfx_state_e state_q, state_d;
    bsfx_cmd_s cmd_q, cmd_d;
    logic [7:0] flags_q, flags_d;
    logic [7:0] wreg_q [NUM_REGS];
    logic [7:0] wreg_d [NUM_REGS];
    logic [7:0] io_q [NUM_REGS];
    logic [7:0] io_d [NUM_REGS];
    logic ready_q, ready_d;
    logic err_q, err_d;
    logic [31:0] rdata_q, rdata_d;

    bsfx_cmd_s curCmd;
    bsfx_region_e region;
    logic [IDX_W-1:0] idx;
    logic hit;
    logic cmdWr;
    logic [7:0] rv;
    logic [7:0] res;
    logic cy;
    logic shf;

    assign curCmd = '{op: pwdata[CMD_OP_LSB +: OP_W],
                      sel: pwdata[CMD_SEL_LSB +: IDX_W],
                      bitIdx: pwdata[CMD_BIT_LSB +: IDX_W]};
    assign region = regionOf(paddr);
    assign idx = paddr[IDX_LSB +: IDX_W];
    // a write lands only at the edge where pready is seen high
    assign hit = psel && penable && ready_q;
    assign cmdWr = hit && pwrite && region == RG_CMD;
    assign rv = wreg_q[curCmd.sel];
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;

    // ********************
    // shifter
    // ********************
    always_comb begin
        res = rv;
        cy = flags_q[FLAG_C];
        shf = 1'b1;
        case (curCmd.op)
            OP_SHIFT_LEFT_LOGICAL: begin
                res = {rv[6:0], 1'b0};
                cy = rv[7];
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                res = {1'b0, rv[7:1]};
                cy = rv[0];
            end
            OP_ROTATE_LEFT_THROUGH_CARRY: begin
                res = {rv[6:0], flags_q[FLAG_C]};
                cy = rv[7];
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                res = {flags_q[FLAG_C], rv[7:1]};
                cy = rv[0];
            end
            OP_SHIFT_RIGHT_ARITHMETIC: begin
                res = {rv[7], rv[7:1]};
                cy = rv[0];
            end
            default: begin
                shf = 1'b0;
            end
        endcase
    end

    // ********************
    // next state
    // ********************
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        flags_d = flags_q;
        wreg_d = wreg_q;
        io_d = io_q;
        ready_d = 1'b0;
        err_d = 1'b0;
        rdata_d = rdata_q;
        // answer one cycle into the access, held off while a clear runs
        if (psel && penable && !ready_q && state_q == ST_IDLE) begin
            ready_d = 1'b1;
            err_d = region == RG_NONE;
            unique case (region)
                // read back in the same layout software wrote it
                RG_CMD: begin
                    rdata_d = '0;
                    rdata_d[CMD_OP_LSB +: OP_W] = cmd_q.op;
                    rdata_d[CMD_SEL_LSB +: IDX_W] = cmd_q.sel;
                    rdata_d[CMD_BIT_LSB +: IDX_W] = cmd_q.bitIdx;
                end
                RG_FLAGS: rdata_d = 32'(flags_q);
                RG_STAT: rdata_d = '0;
                RG_WREG: rdata_d = 32'(wreg_q[idx]);
                RG_IO: rdata_d = 32'(io_q[idx]);
                RG_NONE: rdata_d = '0;
            endcase
        end
        if (state_q == ST_CLRIO) begin
            io_d[cmd_q.sel][cmd_q.bitIdx] = 1'b0;
            state_d = ST_IDLE;
        end
        if (hit && pwrite) begin
            unique case (region)
                RG_FLAGS: flags_d = pwdata[7:0];
                RG_WREG: wreg_d[idx] = pwdata[7:0];
                RG_IO: io_d[idx] = pwdata[7:0];
                RG_CMD, RG_STAT, RG_NONE: begin
                end
            endcase
        end
        if (cmdWr) begin
            cmd_d = curCmd;
            if (shf) begin
                wreg_d[curCmd.sel] = res;
                flags_d[FLAG_C] = cy;
                flags_d[FLAG_Z] = res == REG_RST;
                flags_d[FLAG_N] = res[7];
                flags_d[FLAG_V] = res[7] ^ cy;
            end
            case (curCmd.op)
                OP_CLEAR_IO_BIT: state_d = ST_CLRIO;
                OP_SWAP_NIBBLES: wreg_d[curCmd.sel] = {rv[3:0], rv[7:4]};
                OP_SET_STATUS_FLAG: flags_d[curCmd.bitIdx] = 1'b1;
                OP_CLEAR_STATUS_FLAG: flags_d[curCmd.bitIdx] = 1'b0;
                OP_STORE_BIT_TO_TRANSFER_FLAG:
                    flags_d[FLAG_T] = rv[curCmd.bitIdx];
                OP_LOAD_BIT_FROM_TRANSFER_FLAG:
                    wreg_d[curCmd.sel][curCmd.bitIdx] = flags_q[FLAG_T];
                default: begin
                end
            endcase
            if (curCmd.op[OP_DED_BIT]) begin
                flags_d[curCmd.op[2:0]] = !curCmd.op[OP_DED_CLR_BIT];
            end
        end
        if (region == RG_STAT) begin
            rdata_d[STAT_BUSY] = ready_d && state_q != ST_IDLE;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cmd_q <= '0;
            flags_q <= FLAGS_RST;
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
            for (int i = 0; i < NUM_REGS; i++) begin
                wreg_q[i] <= REG_RST;
                io_q[i] <= REG_RST;
            end
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            flags_q <= flags_d;
            ready_q <= ready_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
            wreg_q <= wreg_d;
            io_q <= io_d;
        end
    end

    // ********************
    // checks
    // ********************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence sCmd(logic [4:0] code);
        cmdWr && curCmd.op == code;
    endsequence

    a_clrio_two_cyc: assert property (
        sCmd(OP_CLEAR_IO_BIT) |=> state_q == ST_CLRIO ##1
        (state_q == ST_IDLE && !io_q[cmd_q.sel][cmd_q.bitIdx]
         && flags_q == $past(flags_q, 2)))
        else $error("io bit clear wrong");
    a_shl_result: assert property (
        sCmd(OP_SHIFT_LEFT_LOGICAL) |=>
        wreg_q[cmd_q.sel] == {$past(rv[6:0]), 1'b0})
        else $error("shift left wrong");
    a_shr_result: assert property (
        sCmd(OP_SHIFT_RIGHT_LOGICAL) |=>
        wreg_q[cmd_q.sel] == {1'b0, $past(rv[7:1])})
        else $error("shift right wrong");
    a_rol_carry: assert property (
        sCmd(OP_ROTATE_LEFT_THROUGH_CARRY) |=>
        flags_q[FLAG_C] == $past(rv[7]) &&
        wreg_q[cmd_q.sel][0] == $past(flags_q[FLAG_C]))
        else $error("rotate left wrong");
    a_ror_carry: assert property (
        sCmd(OP_ROTATE_RIGHT_THROUGH_CARRY) |=>
        flags_q[FLAG_C] == $past(rv[0]) &&
        wreg_q[cmd_q.sel][7] == $past(flags_q[FLAG_C]))
        else $error("rotate right wrong");
    a_asr_sign: assert property (
        sCmd(OP_SHIFT_RIGHT_ARITHMETIC) |=>
        wreg_q[cmd_q.sel] == {$past(rv[7]), $past(rv[7:1])})
        else $error("arith shift wrong");
    a_swap_nibbles: assert property (
        sCmd(OP_SWAP_NIBBLES) |=> flags_q == $past(flags_q) &&
        wreg_q[cmd_q.sel] == {$past(rv[3:0]), $past(rv[7:4])})
        else $error("swap wrong");
    a_bst_tflag: assert property (
        sCmd(OP_STORE_BIT_TO_TRANSFER_FLAG) |=>
        flags_q[FLAG_T] == $past(rv[curCmd.bitIdx]))
        else $error("bit store wrong");
    a_ded_flag: assert property (
        cmdWr && curCmd.op[OP_DED_BIT] |=>
        flags_q[cmd_q.op[2:0]] == !cmd_q.op[OP_DED_CLR_BIT] &&
        $countones(flags_q ^ $past(flags_q)) <= 1)
        else $error("dedicated flag wrong");
    a_zero_flag: assert property (
        cmdWr && shf |=> flags_q[FLAG_Z] == (wreg_q[cmd_q.sel] == '0))
        else $error("zero flag wrong");

endmodule

// [tb/bit_shift_flag_exec_unit_tb.sv]
// self-checking bench for the bit, shift and flag execution unit
// assumes the unit's own assertions sit in its design file; apb on mclk
`timescale 1ns/1ns
module bit_shift_flag_exec_unit_tb
    import bsfx_pkg::*;
;
    typedef struct packed {
        logic [4:0] op;
        logic [2:0] bitIdx;
        logic [7:0] rin;
        logic [7:0] fin;
        logic [7:0] rexp;
        logic [7:0] fexp;
    } bsfx_row_s;

    // ********************
    // ordinary cases: op on working register 2
    // ********************
    localparam bsfx_row_s ROWS [10] = '{
        '{OP_SHIFT_LEFT_LOGICAL, 3'h0, 8'h81, 8'h30, 8'h02, 8'h39},
        '{OP_SHIFT_RIGHT_LOGICAL, 3'h0, 8'h01, 8'hf0, 8'h00, 8'hfb},
        '{OP_ROTATE_LEFT_THROUGH_CARRY, 3'h0, 8'h80, 8'h01, 8'h01, 8'h09},
        '{OP_ROTATE_RIGHT_THROUGH_CARRY, 3'h0, 8'h02, 8'h01, 8'h81, 8'h0c},
        '{OP_SHIFT_RIGHT_ARITHMETIC, 3'h0, 8'h85, 8'h00, 8'hc2, 8'h05},
        '{OP_SWAP_NIBBLES, 3'h0, 8'h3c, 8'h5a, 8'hc3, 8'h5a},
        '{OP_SET_STATUS_FLAG, 3'h5, 8'h11, 8'h00, 8'h11, 8'h20},
        '{OP_CLEAR_STATUS_FLAG, 3'h7, 8'h11, 8'hff, 8'h11, 8'h7f},
        '{OP_STORE_BIT_TO_TRANSFER_FLAG, 3'h3, 8'h08, 8'h00, 8'h08, 8'h40},
        '{OP_LOAD_BIT_FROM_TRANSFER_FLAG, 3'h6, 8'h00, 8'h40, 8'h40, 8'h40}
    };
    localparam logic [7:0] WR2 = 8'h28;
    localparam logic [7:0] IO3 = 8'h4c;

    logic mclk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rdata;
    logic rerr;
    logic hung;
    int waitCnt;
    int errTotal;
    int nCompared;

    bsfx_exec_unit u_dut (
        .mclk(mclk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    function automatic logic [31:0] cmdWord(logic [4:0] op, logic [2:0] s,
                                            logic [2:0] b);
        return {17'h0, b, 1'b0, s, 3'h0, op};
    endfunction

    // ********************
    // bus and comparison tasks
    // ********************
    // called just after an edge; psel stays up so calls chain back to back
    task automatic xfer(logic [7:0] a, logic w, logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        waitCnt = 0;
        do begin
            @(posedge mclk);
            waitCnt++;
        end while (pready !== 1'b1 && waitCnt < 20);
        if (pready !== 1'b1) hung = 1'b1;
        rdata = prdata;
        rerr = pslverr;
        penable <= 1'b0;
    endtask

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic completeRun();
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a stuck handshake ends the run here rather than in the bus task
    initial begin : watchdog
        int k;
        k = 0;
        while (!hung && k < 50000) begin
            @(posedge mclk);
            k++;
        end
        errTotal++;
        completeRun();
    end

    initial begin
        logic [7:0] m;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hung = 1'b0;
        errTotal = 0;
        nCompared = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        xfer(OFF_FLAGS, 1'b0, 32'h0);
        check(rdata, {24'h0, FLAGS_RST});
        check({31'h0, rerr}, 32'h0);
        check(waitCnt, 2);
        xfer(WR2, 1'b0, 32'h0);
        check(rdata, {24'h0, REG_RST});
        for (int i = 0; i < 10; i++) begin
            xfer(OFF_FLAGS, 1'b1, {24'h0, ROWS[i].fin});
            xfer(WR2, 1'b1, {24'h0, ROWS[i].rin});
            xfer(OFF_CMD, 1'b1, cmdWord(ROWS[i].op, 3'h2, ROWS[i].bitIdx));
            xfer(WR2, 1'b0, 32'h0);
            check(rdata, {24'h0, ROWS[i].rexp});
            xfer(OFF_FLAGS, 1'b0, 32'h0);
            check(rdata, {24'h0, ROWS[i].fexp});
        end
        for (int f = 0; f < 8; f++) begin
            m = 8'h01 << f;
            xfer(OFF_FLAGS, 1'b1, 32'h0);
            xfer(OFF_CMD, 1'b1, cmdWord(5'h10 | 5'(f), 3'h0, 3'h0));
            xfer(OFF_FLAGS, 1'b0, 32'h0);
            check(rdata, {24'h0, m});
            xfer(OFF_FLAGS, 1'b1, 32'hff);
            xfer(OFF_CMD, 1'b1, cmdWord(5'h18 | 5'(f), 3'h0, 3'h0));
            xfer(OFF_FLAGS, 1'b0, 32'h0);
            check(rdata, {24'h0, ~m});
        end
        // io bit clear, back to back read
        xfer(IO3, 1'b1, 32'hff);
        xfer(OFF_FLAGS, 1'b1, 32'ha5);
        xfer(OFF_CMD, 1'b1, cmdWord(OP_CLEAR_IO_BIT, 3'h3, 3'h4));
        xfer(IO3, 1'b0, 32'h0);
        // the clear finishes during the setup cycle, so no extra wait
        check(waitCnt, 2);
        check(rdata, 32'hef);
        xfer(OFF_FLAGS, 1'b0, 32'h0);
        check(rdata, 32'ha5);
        // refused accesses and a write to the status register leave state alone
        xfer(8'h1c, 1'b0, 32'h0);
        check({31'h0, rerr}, 32'h1);
        check(rdata, 32'h0);
        xfer(8'h21, 1'b1, 32'h55);
        check({31'h0, rerr}, 32'h1);
        xfer(8'h20, 1'b0, 32'h0);
        check(rdata, 32'h0);
        xfer(OFF_STAT, 1'b1, 32'h1);
        xfer(OFF_STAT, 1'b0, 32'h0);
        check(rdata, 32'h0);
        // unknown opcode is latched but changes nothing
        xfer(OFF_FLAGS, 1'b1, 32'h5a);
        xfer(WR2, 1'b1, 32'h81);
        xfer(OFF_CMD, 1'b1, cmdWord(5'h0b, 3'h2, 3'h1));
        xfer(WR2, 1'b0, 32'h0);
        check(rdata, 32'h81);
        xfer(OFF_FLAGS, 1'b0, 32'h0);
        check(rdata, 32'h5a);
        xfer(OFF_CMD, 1'b0, 32'h0);
        check(rdata, 32'h120b);
        check({31'h0, rerr}, 32'h0);
        // second reset in mid-run clears the flags
        xfer(OFF_FLAGS, 1'b1, 32'hff);
        psel <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        check({31'h0, pready}, 32'h0);
        rst <= 1'b0;
        @(posedge mclk);
        xfer(OFF_FLAGS, 1'b0, 32'h0);
        check(rdata, {24'h0, FLAGS_RST});
        psel <= 1'b0;
        @(posedge mclk);
        completeRun();
    end
endmodule
